//--- pkg/decode_map.svh
`ifndef DECODE_MAP_SVH
`define DECODE_MAP_SVH

// Instruction word geometry
`define INSTR_W 12
`define OPC_HI 11
`define OPC_BYTE_LO 6
`define OPC_BIT_LO 8
`define OPC_JUMP_LO 9
`define DEST_POS 5
`define FILE_HI 4
`define BSEL_HI 7
`define BSEL_LO 5
`define LIT_HI 7
`define TARGET_HI 8

// Opcode patterns used by the classifier and timing logic
`define CTRL_PREFIX 7'h00
`define JUMP_OP 3'h5
`define CALL_OP 4'h9
`define RETLW_OP 4'h8
`define CLR_OP 6'h01
`define NOP_WORD 12'h000

// Identification store
`define ID_WORDS 4
`define ID_RESET 12'hfff

// Timing: oscillator periods per instruction cycle
`define OSC_PERIOD_NS 40
`define CYCLE_PERIODS 4

// Reset values
`define W_RESET 8'h00

`endif

//--- pkg/decode_pkg.sv
package decode_pkg;

   // Oscillator quarter within one instruction cycle
   typedef enum logic [3:0] {
      PH_Q1 = 4'h1,
      PH_Q2 = 4'h2,
      PH_Q3 = 4'h4,
      PH_Q4 = 4'h8
   } phase_t;

   // Instruction class
   typedef enum logic [2:0] {
      CL_BYTE = 3'h1,
      CL_BIT = 3'h2,
      CL_LIT = 3'h4
   } op_class_t;

   // Phase generator state
   typedef struct packed {
      phase_t ph;
      logic start;
   } phase_state_t;

   // Identification store state
   typedef struct packed {
      logic [3:0][11:0] mem;
      logic [11:0] rdata;
      logic rvalid;
      logic prog_meta;
      logic prog;
   } id_state_t;

   // Decoder state
   typedef struct packed {
      logic [11:0] word;
      op_class_t cls;
      logic [5:0] opcode;
      logic dest_file;
      logic [6:0] faddr;
      logic [2:0] bsel;
      logic [7:0] bmask;
      logic [7:0] lit;
      logic [8:0] target;
      logic pc_wr;
      logic pc8_zero;
      logic wr_w;
      logic flushed;
      logic skip_seen;
      logic [7:0] w;
      logic file_wr;
      logic [7:0] file_wdata;
   } dec_state_t;

endpackage

//--- rtl/cycle_phase.sv
`timescale 1ns/1ps
`include "decode_map.svh"

// Splits the oscillator into four-quarter instruction cycles
module cycle_phase
   import decode_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Phase outputs
   output phase_t phase,
   output logic cycle_start
);

   phase_state_t s_q; // Registered state
   phase_state_t s_d; // Next state

   // Rotate through the four quarters
   always_comb begin
      s_d = s_q;
      case (s_q.ph)
         PH_Q1: s_d.ph = PH_Q2;
         PH_Q2: s_d.ph = PH_Q3;
         PH_Q3: s_d.ph = PH_Q4;
         PH_Q4: s_d.ph = PH_Q1;
         default: s_d.ph = PH_Q1;
      endcase
      // One pulse as each new cycle opens
      s_d.start = (s_q.ph == PH_Q4);
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_q <= '{ph: PH_Q4, start: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign phase = s_q.ph;
   assign cycle_start = s_q.start;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   four_period_cycle_a: assert property (
      cycle_start |-> phase == PH_Q1 ##1 !cycle_start [*3] ##1 cycle_start)
      else $error("cycle is not four oscillator periods");
   phase_onehot_a: assert property ($onehot(phase))
      else $error("phase not one-hot");

endmodule // cycle_phase

//--- rtl/id_store.sv
`timescale 1ns/1ps
`include "decode_map.svh"

// Four identification words, reachable only in program/verify mode
module id_store
   import decode_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Program/verify pin, asynchronous
   input wire logic prog_pin,
   // Programmer access
   input wire logic [1:0] id_index,
   input wire logic [11:0] id_wdata,
   input wire logic id_wr,
   input wire logic id_rd,
   // Answers
   output logic [11:0] id_rdata,
   output logic id_rvalid,
   output logic prog_mode
);

   id_state_t s_q; // Registered state
   id_state_t s_d; // Next state

   // Access only while the synchronised mode level is high
   always_comb begin
      s_d = s_q;
      s_d.prog_meta = prog_pin;
      s_d.prog = s_q.prog_meta;
      s_d.rvalid = 1'b0;
      if (s_q.prog && id_wr) begin
         s_d.mem[id_index] = id_wdata;
      end
      if (s_q.prog && id_rd) begin
         s_d.rdata = s_q.mem[id_index];
         s_d.rvalid = 1'b1;
      end
   end

   // State register; words start erased
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_q <= '{mem: {`ID_WORDS{`ID_RESET}}, rdata: 12'h000,
                  rvalid: 1'b0, prog_meta: 1'b0, prog: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign id_rdata = s_q.rdata;
   assign id_rvalid = s_q.rvalid;
   assign prog_mode = s_q.prog;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   id_write_locked_a: assert property (
      !prog_mode && id_wr |=> $stable(s_q.mem))
      else $error("id word changed outside program mode");
   id_read_locked_a: assert property (
      !prog_mode |=> !id_rvalid)
      else $error("id read answered outside program mode");
   id_read_back_a: assert property (
      prog_mode && id_rd && !id_wr |=> id_rvalid &&
      id_rdata == $past(s_q.mem[id_index]))
      else $error("id read returned wrong word");
   id_access_c: cover property (prog_mode && id_wr ##1 id_rd);

endmodule // id_store

//--- rtl/instr_decode.sv
`timescale 1ns/1ps
`include "decode_map.svh"

// Operation
// - Four ID words, access only in programming
// - Each instruction is one 12-bit word
// - Classify byte, bit, or literal/control
// - Byte ops pick one of 32 files
// - Destination bit: 0 to W, 1 to file
// - Bit select chooses bit of file register
// - Literal is 8 bits, 9 for jump
// - Don't-care bits never change behaviour
// - File address space spans 0x00 to 0x7f
// - Working accumulator is implicit operand, destination
// - One cycle; taken test or branch two
// - Instruction cycle is four oscillator periods
// - Byte fields: opcode 11:6, d 5, f 4:0
// - Bit fields: opcode 11:8, b 7:5, f 4:0
// - Jump opcode 11:9, target 8:0
// - Non-jump program counter writes zero bit eight
module instr_decode
   import decode_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Program memory word
   input wire logic [11:0] instr_word,
   // Datapath feedback
   input wire logic cond_true,
   input wire logic [1:0] bank_sel,
   input wire logic [7:0] result_data,
   input wire logic result_valid,
   // Programming side
   input wire logic prog_pin,
   input wire logic [1:0] id_index,
   input wire logic [11:0] id_wdata,
   input wire logic id_wr,
   input wire logic id_rd,
   output logic [11:0] id_rdata,
   output logic id_rvalid,
   output logic prog_mode,
   // Cycle timing
   output phase_t phase,
   output logic cycle_start,
   // Decoded fields
   output op_class_t op_class,
   output logic [5:0] opcode,
   output logic dest_file,
   output logic [6:0] file_addr,
   output logic [2:0] bit_sel,
   output logic [7:0] bit_mask,
   output logic [7:0] literal,
   output logic [8:0] jump_target,
   // Flow control
   output logic pc_write,
   output logic pc_bit8_zero,
   output logic flushed,
   // Result routing
   output logic writes_w,
   output logic [7:0] w_value,
   output logic file_wr,
   output logic [7:0] file_wdata
);

   dec_state_t s_q; // Registered state
   dec_state_t s_d; // Next state
   logic [11:0] word_in; // Word actually decoded this cycle
   logic [7:0] mask_w; // One-hot bit mask of the incoming word
   logic discard; // Slot after a skip or branch is thrown away

   // Quarter generator; its outputs are registered in there, so phase
   // and cycle_start leave this block straight from flops
   cycle_phase cycle_phase_inst (
      .clk(clk),
      .rstn(rstn),
      .phase(phase),
      .cycle_start(cycle_start)
   );

   // Identification words; the mode pin is synchronised in there and
   // only the second flop of that pair reaches any logic
   id_store id_store_inst (
      .clk(clk),
      .rstn(rstn),
      .prog_pin(prog_pin),
      .id_index(id_index),
      .id_wdata(id_wdata),
      .id_wr(id_wr),
      .id_rd(id_rd),
      .id_rdata(id_rdata),
      .id_rvalid(id_rvalid),
      .prog_mode(prog_mode)
   );

   // Discard the prefetched word after a skip or branch, and while
   // programming so that the core never executes during verify.
   // cond_true is used directly, not only through skip_seen, so that a
   // test decided on the last quarter edge still catches the word
   // sampled on that same edge. Program mode discards too but is not
   // reported as flushed: nothing was skipped, the core is only held.
   always_comb begin
      discard = s_q.skip_seen || cond_true || s_q.pc_wr;
      if (discard || prog_mode) begin
         word_in = `NOP_WORD;
      end else begin
         word_in = instr_word;
      end
   end

   // Bit mask, one decoder per bit position; held in a register so
   // the datapath needs no shifter of its own in a bit cycle
   for (genvar i = 0; i < 8; i++) begin : g_mask
      assign mask_w[i] = (word_in[`BSEL_HI:`BSEL_LO] == 3'(i));
   end

   // Decode at each cycle boundary, route results during the cycle.
   // Fields are taken only on the last quarter edge; the fetch bus is
   // not promised stable in the other three quarters. A result that
   // arrives on that same edge is dropped, since the fields are about
   // to change under it; the datapath must strobe in quarters one to
   // three.
   always_comb begin
      s_d = s_q;
      s_d.file_wr = 1'b0;
      // Skip request kept until the boundary; clear at the boundary wins over set
      if (cond_true) begin
         s_d.skip_seen = 1'b1;
      end
      if (phase == PH_Q4) begin
         s_d.word = word_in;
         s_d.flushed = discard && !prog_mode;
         s_d.skip_seen = 1'b0;
         s_d.faddr = {bank_sel, word_in[`FILE_HI:0]};
         s_d.dest_file = word_in[`DEST_POS];
         s_d.bsel = word_in[`BSEL_HI:`BSEL_LO];
         s_d.bmask = mask_w;
         s_d.lit = word_in[`LIT_HI:0];
         s_d.target = word_in[`TARGET_HI:0];
         s_d.pc_wr = 1'b0;
         s_d.pc8_zero = 1'b0;
         s_d.wr_w = 1'b0;
         // Class from the top bits only
         if (word_in[`OPC_HI]) begin
            s_d.cls = CL_LIT;
            s_d.opcode = {2'b00, word_in[`OPC_HI:`OPC_BIT_LO]};
            s_d.dest_file = 1'b0;
            if (word_in[`OPC_HI:`OPC_JUMP_LO] == `JUMP_OP) begin
               // Jump keeps all nine target bits
               s_d.opcode = {3'b000, word_in[`OPC_HI:`OPC_JUMP_LO]};
               s_d.pc_wr = 1'b1;
            end else if (word_in[`OPC_HI:`OPC_BIT_LO] == `CALL_OP ||
                         word_in[`OPC_HI:`OPC_BIT_LO] == `RETLW_OP) begin
               s_d.pc_wr = 1'b1;
               s_d.pc8_zero = 1'b1;
               s_d.target = {1'b0, word_in[`LIT_HI:0]};
               s_d.wr_w = (word_in[`OPC_HI:`OPC_BIT_LO] == `RETLW_OP);
            end else begin
               // Literal arithmetic lands in W
               s_d.wr_w = word_in[`OPC_HI - 1];
            end
         end else if (word_in[`OPC_HI - 1]) begin
            s_d.cls = CL_BIT;
            s_d.opcode = {2'b00, word_in[`OPC_HI:`OPC_BIT_LO]};
            s_d.dest_file = 1'b1;
         end else if (word_in[`OPC_HI:`DEST_POS] == `CTRL_PREFIX) begin
            // Short control words live in the byte encoding space
            s_d.cls = CL_LIT;
            s_d.opcode = 6'h00;
            s_d.dest_file = 1'b0;
         end else begin
            s_d.cls = CL_BYTE;
            s_d.opcode = word_in[`OPC_HI:`OPC_BYTE_LO];
            s_d.wr_w = !word_in[`DEST_POS];
            // Clear-W ignores its file field, whatever it holds
            if (word_in[`OPC_HI:`OPC_BYTE_LO] == `CLR_OP &&
                !word_in[`DEST_POS]) begin
               s_d.faddr = {bank_sel, 5'h00};
            end
         end
      end else if (result_valid && !s_q.flushed) begin
         // Datapath result goes to W or back to the file
         if (s_q.wr_w) begin
            s_d.w = result_data;
         end else if (s_q.cls != CL_LIT) begin
            s_d.file_wr = 1'b1;
            s_d.file_wdata = result_data;
         end
      end
   end

   // State register; reset only synchronously, so the decoder comes
   // out of reset on a NOP with W cleared and nothing pending
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_q <= '{word: `NOP_WORD, cls: CL_LIT, opcode: 6'h00,
                  dest_file: 1'b0, faddr: 7'h00, bsel: 3'h0,
                  bmask: 8'h01, lit: 8'h00, target: 9'h000,
                  pc_wr: 1'b0, pc8_zero: 1'b0, wr_w: 1'b0,
                  flushed: 1'b0, skip_seen: 1'b0, w: `W_RESET,
                  file_wr: 1'b0, file_wdata: 8'h00};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register, so no output of this
   // block has a combinational path from any input
   assign op_class = s_q.cls;
   assign opcode = s_q.opcode;
   assign dest_file = s_q.dest_file;
   assign file_addr = s_q.faddr;
   assign bit_sel = s_q.bsel;
   assign bit_mask = s_q.bmask;
   assign literal = s_q.lit;
   assign jump_target = s_q.target;
   assign pc_write = s_q.pc_wr;
   assign pc_bit8_zero = s_q.pc8_zero;
   assign flushed = s_q.flushed;
   assign writes_w = s_q.wr_w;
   assign w_value = s_q.w;
   assign file_wr = s_q.file_wr;
   assign file_wdata = s_q.file_wdata;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // Fields taken from the decoded word
   byte_fields_a: assert property (
      cycle_start && op_class == CL_BYTE |->
      opcode == s_q.word[11:6] && dest_file == s_q.word[5] &&
      (file_addr[4:0] == s_q.word[4:0] || opcode == `CLR_OP))
      else $error("byte field split wrong");
   bit_fields_a: assert property (
      cycle_start && op_class == CL_BIT |->
      bit_sel == s_q.word[7:5] && file_addr[4:0] == s_q.word[4:0] &&
      bit_mask == (8'h01 << s_q.word[7:5]))
      else $error("bit field split wrong");
   jump_target_a: assert property (
      cycle_start && s_q.word[11:9] == `JUMP_OP |->
      pc_write && jump_target == s_q.word[8:0] && !pc_bit8_zero)
      else $error("jump target wrong");
   pc_bit8_clear_a: assert property (
      cycle_start && pc_write && s_q.word[11:9] != `JUMP_OP |->
      pc_bit8_zero && !jump_target[8])
      else $error("ninth pc bit not cleared");
   // A branch costs a second cycle, spent on a flushed NOP
   branch_flush_a: assert property (
      cycle_start && pc_write ##3 !prog_mode |=>
      flushed && s_q.word == `NOP_WORD)
      else $error("word after branch not discarded");
   // A true test early in the cycle is held until the boundary
   skip_flush_a: assert property (
      cond_true && phase == PH_Q2 && !prog_mode ##2 !prog_mode |=>
      flushed && s_q.word == `NOP_WORD)
      else $error("skip did not cost a second cycle");
   // A test that turns true on the last quarter edge still counts
   skip_late_a: assert property (
      cond_true && phase == PH_Q4 && !prog_mode |=> flushed)
      else $error("late skip not honoured");
   // No skip and no branch: the next slot executes normally
   single_cycle_a: assert property (
      cycle_start && !pc_write && !cond_true ##1 !cond_true [*3] |=>
      !flushed)
      else $error("plain instruction took a second cycle");
   class_onehot_a: assert property ($onehot(op_class))
      else $error("class not one-hot");
   // Result routing into W or back to the file
   w_dest_a: assert property (
      result_valid && writes_w && phase != PH_Q4 && !flushed |=>
      w_value == $past(result_data) && !file_wr)
      else $error("result not placed in W");
   file_dest_a: assert property (
      result_valid && !writes_w && op_class == CL_BYTE &&
      phase != PH_Q4 && !flushed |=> file_wr)
      else $error("result not written to file");
   // Programming holds the core on NOPs
   prog_halt_a: assert property (
      prog_mode && phase == PH_Q4 |=> s_q.word == `NOP_WORD)
      else $error("core executed during program mode");
   // Literal, bank bits, clear-W and accumulator hold
   literal_field_a: assert property (
      cycle_start && op_class == CL_LIT |-> literal == s_q.word[7:0])
      else $error("literal field wrong");
   file_bank_a: assert property (
      cycle_start |-> file_addr[6:5] == $past(bank_sel))
      else $error("file address bank bits wrong");
   clear_w_a: assert property (
      cycle_start && op_class == CL_BYTE && opcode == `CLR_OP &&
      !dest_file |-> file_addr[4:0] == 5'h00)
      else $error("clear-W file field not ignored");
   w_hold_a: assert property (
      !(result_valid && writes_w && phase != PH_Q4 && !flushed) |=>
      $stable(w_value))
      else $error("W changed without a result");

   // Main scenarios worth seeing at least once
   byte_op_c: cover property (cycle_start && op_class == CL_BYTE);
   bit_op_c: cover property (cycle_start && op_class == CL_BIT);
   jump_c: cover property (cycle_start && pc_write ##4 flushed);
   skip_c: cover property (cond_true ##[1:4] cycle_start && flushed);

endmodule // instr_decode

//--- dv/core_side_model.sv
`timescale 1ns/1ps

// Program memory and datapath as the decoder sees them
module core_side_model
   import decode_pkg::*;
(
   // Clock and decoder timing
   input wire logic clk,
   input wire phase_t phase,
   // Values chosen by the bench
   input wire logic [11:0] word_in,
   input wire logic [1:0] bank_in,
   input wire logic [7:0] res_in,
   // Towards the decoder
   output logic [11:0] instr_word,
   output logic [1:0] bank_sel,
   output logic [7:0] result_data,
   output logic result_valid
);
   // Quiet bus at time zero
   initial begin
      instr_word = 12'h000;
      bank_sel = 2'h0;
      result_data = 8'h00;
      result_valid = 1'b0;
   end

   // Fetch bus valid only in the last quarter; inverted otherwise so a
   // decoder sampling on the wrong edge picks up a wrong word
   always @(posedge clk) begin
      #1;
      if (phase == PH_Q4) begin
         instr_word <= word_in;
         bank_sel <= bank_in;
      end else begin
         instr_word <= ~word_in;
         bank_sel <= ~bank_in;
      end
      // One-clock result strobe in the second quarter
      result_valid <= (phase == PH_Q2);
      result_data <= (phase == PH_Q2) ? res_in : ~res_in;
   end
endmodule // core_side_model

//--- dv/instr_decode_bench.sv
`timescale 1ns/1ps

`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
   err_total++; $display("wrong value at %0t: %h vs %h", $time, a, e); \
   end end

// Self-checking bench for the instruction decoder
module instr_decode_bench;
   import decode_pkg::*;
   logic clk = 1'b0; // Oscillator
   logic rstn = 1'b0; // Sync reset
   logic [11:0] word_in = 12'h000; // Next program word
   logic [1:0] bank_in = 2'h2; // Upper file address bits
   logic [7:0] res_in = 8'h00; // Next datapath result
   logic cond_true = 1'b0; // Skip decision
   logic prog_pin = 1'b0; // Program/verify pin
   logic [1:0] id_index = 2'h0;
   logic [11:0] id_wdata = 12'h000;
   logic id_wr = 1'b0;
   logic id_rd = 1'b0;
   logic [11:0] instr_word, id_rdata;
   logic [1:0] bank_sel;
   logic [7:0] result_data, bit_mask, literal, w_value, file_wdata;
   logic result_valid, id_rvalid, prog_mode, cycle_start, dest_file;
   logic pc_write, pc_bit8_zero, flushed, writes_w, file_wr;
   phase_t phase;
   op_class_t op_class;
   logic [5:0] opcode;
   logic [6:0] file_addr;
   logic [2:0] bit_sel;
   logic [8:0] jump_target;
   int err_total = 0;
   int total_checks = 0;

   // 25 MHz oscillator
   always #20 clk = ~clk;

   instr_decode instr_decode_inst (.clk(clk), .rstn(rstn),
      .instr_word(instr_word), .cond_true(cond_true),
      .bank_sel(bank_sel), .result_data(result_data),
      .result_valid(result_valid), .prog_pin(prog_pin),
      .id_index(id_index), .id_wdata(id_wdata), .id_wr(id_wr),
      .id_rd(id_rd), .id_rdata(id_rdata), .id_rvalid(id_rvalid),
      .prog_mode(prog_mode), .phase(phase), .cycle_start(cycle_start),
      .op_class(op_class), .opcode(opcode), .dest_file(dest_file),
      .file_addr(file_addr), .bit_sel(bit_sel), .bit_mask(bit_mask),
      .literal(literal), .jump_target(jump_target),
      .pc_write(pc_write), .pc_bit8_zero(pc_bit8_zero),
      .flushed(flushed), .writes_w(writes_w), .w_value(w_value),
      .file_wr(file_wr), .file_wdata(file_wdata));

   core_side_model core_side_model_inst (.clk(clk), .phase(phase),
      .word_in(word_in), .bank_in(bank_in), .res_in(res_in),
      .instr_word(instr_word), .bank_sel(bank_sel),
      .result_data(result_data), .result_valid(result_valid));

   // Verdict and end of run
   task automatic results;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Queue one word and wait until its fields show
   task automatic step(input logic [11:0] w);
      int n;
      n = 0;
      word_in = w;
      @(posedge clk) #2;
      while (cycle_start !== 1'b1 && n < 8) begin
         @(posedge clk) #2;
         n++;
      end
      `CHK(n < 8, 1'b1)
   endtask

   // Four quarters per instruction cycle, one-hot in order
   task automatic t_phase;
      phase_t seq [4];
      seq = '{PH_Q2, PH_Q3, PH_Q4, PH_Q1};
      step(12'h000);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) #2;
         `CHK(phase, seq[i])
         `CHK(cycle_start, (i == 3))
      end
   endtask

   // Byte class: fields, destination, result routing
   task automatic t_byte;
      step(12'h1e5);
      `CHK(op_class, CL_BYTE)
      `CHK(opcode, 6'h07)
      `CHK(file_addr, 7'h45)
      `CHK(dest_file, 1'b1)
      res_in = 8'h3c;
      repeat (2) @(posedge clk) #2;
      `CHK(file_wr, 1'b1)
      `CHK(file_wdata, 8'h3c)
      step(12'h1c5);
      `CHK(writes_w, 1'b1)
      res_in = 8'h5a;
      repeat (2) @(posedge clk) #2;
      `CHK(file_wr, 1'b0)
      `CHK(w_value, 8'h5a)
   endtask

   // Bit class and clear-W with nonzero don't-care bits
   task automatic t_bit;
      step(12'h5a3);
      `CHK(op_class, CL_BIT)
      `CHK(opcode, 6'h05)
      `CHK(bit_sel, 3'h5)
      `CHK(bit_mask, 8'h20)
      `CHK(file_addr, 7'h43)
      bank_in = 2'h3;
      step(12'h5bf);
      `CHK(file_addr, 7'h7f)
      bank_in = 2'h2;
      step(12'h05f);
      `CHK(opcode, 6'h01)
      `CHK(file_addr, 7'h40)
      `CHK(dest_file, 1'b0)
   endtask

   // Jump, call and skip, each discarding the following word
   task automatic t_flow;
      step(12'hbff);
      `CHK(jump_target, 9'h1ff)
      `CHK({pc_write, pc_bit8_zero}, 2'b10)
      `CHK(opcode, 6'h05)
      step(12'hc3c);
      `CHK({flushed, literal}, 9'h100)
      step(12'h9ab);
      `CHK(jump_target, 9'h0ab)
      `CHK({pc_write, pc_bit8_zero}, 2'b11)
      step(12'hc3c);
      `CHK(flushed, 1'b1)
      step(12'hc3c);
      `CHK({flushed, literal}, 9'h03c)
      `CHK(op_class, CL_LIT)
      step(12'h6a3);
      cond_true = 1'b1;
      step(12'h1e5);
      `CHK({flushed, op_class}, {1'b1, CL_LIT})
      cond_true = 1'b0;
      step(12'h1e5);
      `CHK({flushed, op_class}, {1'b0, CL_BYTE})
   endtask

   // One identification access pulse
   task automatic id_op(input logic wr, input logic [1:0] i,
                        input logic [11:0] d, output logic [12:0] r);
      id_index = i;
      id_wdata = d;
      id_wr = wr;
      id_rd = ~wr;
      @(posedge clk) #2;
      // Read answer stands for this one clock only
      r = {id_rvalid, id_rdata};
      id_wr = 1'b0;
      id_rd = 1'b0;
      @(posedge clk) #2;
   endtask

   // Identification words locked outside program/verify mode
   task automatic t_id;
      logic [12:0] r;
      id_op(1'b1, 2'h1, 12'h123, r);
      `CHK(r[12], 1'b0)
      id_op(1'b0, 2'h1, 12'h000, r);
      `CHK(r[12], 1'b0)
      prog_pin = 1'b1;
      repeat (3) @(posedge clk) #2;
      `CHK(prog_mode, 1'b1)
      id_op(1'b0, 2'h1, 12'h000, r);
      `CHK(r, 13'h1fff)
      id_op(1'b1, 2'h2, 12'hff5, r);
      id_op(1'b0, 2'h2, 12'h000, r);
      `CHK(r, 13'h1ff5)
      step(12'h1e5);
      `CHK({flushed, op_class}, {1'b0, CL_LIT})
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      #2 rstn = 1'b1;
      t_phase();
      t_byte();
      t_bit();
      t_flow();
      t_id();
      results();
   end

   // Watchdog, far beyond the fewer than a hundred clocks the tests need
   initial begin
      #100000;
      err_total++;
      results();
   end
endmodule // instr_decode_bench
